// [common/crsa_defines.svh]
`ifndef CRSA_DEFINES_SVH
`define CRSA_DEFINES_SVH

// Controller data-space offsets
`define CRSA_OFS_CONTROL   16'h7ff5
`define CRSA_OFS_IDX_LO    16'h7ff6
`define CRSA_OFS_WIN_LO    16'h7ff7
`define CRSA_OFS_IDX_HI    16'h7ff8
`define CRSA_OFS_WIN_HI    16'h7ff9

// Reset values
`define CRSA_RST_CONTROL   8'h80
`define CRSA_RST_INDEX     8'h00
`define CRSA_RST_DATA      8'h00

// Control register bit positions
`define CRSA_BIT_UNAWARE   7
`define CRSA_BIT_CTL_HI    3
`define CRSA_BIT_HOST_HI   2
`define CRSA_BIT_CTL_LO    1
`define CRSA_BIT_HOST_LO   0

// Bank location that mirrors the control register
`define CRSA_MIRROR_LOC    7'h7f
`define CRSA_BANK_DEPTH    128

`endif

// [common/crsa_pkg.sv]
package crsa_pkg;

   // Controller memory-mapped access, one cycle per strobe
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } crsa_bus_type;

   // Host request lines, levels; a rising edge acts
   typedef struct packed {
      logic set_hi;
      logic set_lo;
      logic clr_hi;
      logic clr_lo;
   } crsa_host_type;

   // Who may use each bank
   typedef struct packed {
      logic ctl_hi;
      logic ctl_lo;
      logic host_hi;
      logic host_lo;
   } crsa_grant_type;

endpackage : crsa_pkg

// [src/crsa_arbiter.sv]
// Function
// - Host-unaware flag set grants host always
// - Setting host-unaware flag clears both host requests
// - Clearing host-unaware flag enables request sharing
// - Controller low request needs host low clear
// - Controller high request needs host high clear
// - Host low request needs controller low clear
// - Host high request needs controller high clear
// - Refused request reads back zero; retry
// - Bank owner follows the two request flags
// - Controller may access during reset or power-off
// - Low and high index select two banks
// - Index bit seven ignored in decode
// - Low-bank location 7F mirrors the control register; high-bank 7F is plain storage
// - Window access only while controller holds grant
`timescale 1ns/100ps
`default_nettype none
`include "crsa_defines.svh"

module crsa_arbiter
   import crsa_pkg::*;
#(
   parameter int BANK_DEPTH = `CRSA_BANK_DEPTH
) (
   // Clock and reset
   input  wire logic           clk,
   input  wire logic           resetn,
   // Controller data-space access
   input  wire crsa_bus_type   bus,
   output var  logic [7:0]     rdata,
   // Host request lines and system state pins
   input  wire crsa_host_type  host_req,
   input  wire logic           sys_reset_active,
   input  wire logic           main_power_plane,
   // Bank ownership
   output var  crsa_grant_type grant
);

   if (BANK_DEPTH != 128) begin : g_check
      $error("crsa_arbiter serves two banks of 128 bytes only");
   end

   typedef struct packed {
      logic                 unaware;
      logic                 ctl_lo;
      logic                 ctl_hi;
      logic                 host_lo;
      logic                 host_hi;
      logic [7:0]           idx_lo;
      logic [7:0]           idx_hi;
      logic [7:0]           rdata;
      crsa_grant_type       grant;
      logic [5:0]           sync1;
      logic [5:0]           sync2;
      logic [3:0]           prev;
      logic [255:0][7:0]    ram;
   } crsa_state_type;

   crsa_state_type s_q;
   crsa_state_type s_d;

   // Controller owns a bank; forced open in reset or power-off
   function automatic logic ctl_may(input logic unaware,
                                    input logic ctl_bank_request,
                                    input logic hreq,
                                    input logic force_open);
      ctl_may = force_open | (~unaware & ctl_bank_request & ~hreq);
   endfunction : ctl_may

   function automatic logic [7:0] control_byte(input crsa_state_type s);
      control_byte = {s.unaware, 3'h0, s.ctl_hi, s.host_hi,
                      s.ctl_lo, s.host_lo};
   endfunction : control_byte

   logic [3:0] host_edge;
   logic       force_open;
   logic       wr_ctrl;
   logic       kl_set;
   logic       kh_set;
   logic [7:0] loc_lo;
   logic [7:0] loc_hi;

   always_comb begin
      s_d = s_q;
      s_d.sync1 = {main_power_plane, sys_reset_active, host_req};
      s_d.sync2 = s_q.sync1;
      s_d.prev  = s_q.sync2[3:0];
      host_edge = s_q.sync2[3:0] & ~s_q.prev;
      // Power plane off or system reset opens the RAM to firmware
      force_open = s_q.sync2[4] | ~s_q.sync2[5];

      wr_ctrl = bus.wr && (bus.addr == `CRSA_OFS_CONTROL);
      kl_set  = wr_ctrl && bus.wdata[`CRSA_BIT_CTL_LO]
                && !s_q.host_lo;
      kh_set  = wr_ctrl && bus.wdata[`CRSA_BIT_CTL_HI]
                && !s_q.host_hi;

      // Controller request flags; a refused set leaves 0
      if (kl_set) begin
         s_d.ctl_lo = 1'b1;
      end else if (wr_ctrl && !bus.wdata[`CRSA_BIT_CTL_LO]) begin
         s_d.ctl_lo = 1'b0;
      end
      if (kh_set) begin
         s_d.ctl_hi = 1'b1;
      end else if (wr_ctrl && !bus.wdata[`CRSA_BIT_CTL_HI]) begin
         s_d.ctl_hi = 1'b0;
      end

      // Host flags: a controller set in the same cycle wins
      if (host_edge[2] && !s_q.unaware && !s_q.ctl_lo
          && !kl_set) begin
         s_d.host_lo = 1'b1;
      end else if (host_edge[0]) begin
         s_d.host_lo = 1'b0;
      end
      if (host_edge[3] && !s_q.unaware && !s_q.ctl_hi
          && !kh_set) begin
         s_d.host_hi = 1'b1;
      end else if (host_edge[1]) begin
         s_d.host_hi = 1'b0;
      end

      if (wr_ctrl) begin
         s_d.unaware = bus.wdata[`CRSA_BIT_UNAWARE];
         if (bus.wdata[`CRSA_BIT_UNAWARE]) begin
            s_d.host_lo = 1'b0;
            s_d.host_hi = 1'b0;
         end
      end

      if (bus.wr && bus.addr == `CRSA_OFS_IDX_LO) begin
         s_d.idx_lo = bus.wdata;
      end
      if (bus.wr && bus.addr == `CRSA_OFS_IDX_HI) begin
         s_d.idx_hi = bus.wdata;
      end

      // Bit seven of the index takes no part in the decode
      loc_lo = {1'b0, s_q.idx_lo[6:0]};
      loc_hi = {1'b1, s_q.idx_hi[6:0]};

      // Window writes; the mirror location is not storage
      if (bus.wr && bus.addr == `CRSA_OFS_WIN_LO && s_q.grant.ctl_lo
          && s_q.idx_lo[6:0] != `CRSA_MIRROR_LOC) begin
         s_d.ram[loc_lo] = bus.wdata;
      end
      if (bus.wr && bus.addr == `CRSA_OFS_WIN_HI
          && s_q.grant.ctl_hi) begin
         s_d.ram[loc_hi] = bus.wdata;
      end

      // Read data holds until the next read strobe
      if (bus.rd) begin
         case (bus.addr)
            `CRSA_OFS_CONTROL: s_d.rdata = control_byte(s_q);
            `CRSA_OFS_IDX_LO:  s_d.rdata = s_q.idx_lo;
            `CRSA_OFS_IDX_HI:  s_d.rdata = s_q.idx_hi;
            `CRSA_OFS_WIN_LO: begin
               if (!s_q.grant.ctl_lo) begin
                  s_d.rdata = 8'h00;
               end else if (s_q.idx_lo[6:0] == `CRSA_MIRROR_LOC) begin
                  s_d.rdata = control_byte(s_q);
               end else begin
                  s_d.rdata = s_q.ram[loc_lo];
               end
            end
            `CRSA_OFS_WIN_HI: begin
               s_d.rdata = s_q.grant.ctl_hi ? s_q.ram[loc_hi]
                                            : 8'h00;
            end
            default: s_d.rdata = 8'h00;
         endcase
      end

      // Grants follow the next flag values so outputs stay aligned
      s_d.grant.ctl_lo  = ctl_may(s_d.unaware, s_d.ctl_lo,
                                  s_d.host_lo, force_open);
      s_d.grant.ctl_hi  = ctl_may(s_d.unaware, s_d.ctl_hi,
                                  s_d.host_hi, force_open);
      s_d.grant.host_lo = s_d.unaware | s_d.host_lo;
      s_d.grant.host_hi = s_d.unaware | s_d.host_hi;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q         <= '0;
         s_q.unaware <= 1'(`CRSA_RST_CONTROL >> `CRSA_BIT_UNAWARE);
         s_q.idx_lo  <= `CRSA_RST_INDEX;
         s_q.idx_hi  <= `CRSA_RST_INDEX;
         s_q.rdata   <= `CRSA_RST_DATA;
         s_q.grant   <= 4'h3;
         s_q.sync2   <= 6'h20;
         s_q.sync1   <= 6'h20;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata = s_q.rdata;
   assign grant = s_q.grant;

   property p_unaware_host;
      @(posedge clk) disable iff (!resetn)
      s_q.unaware |-> s_q.grant.host_lo && s_q.grant.host_hi;
   endproperty
   a_unaware_host: assert property (p_unaware_host)
      else $error("host lacks access while host-unaware");

   property p_unaware_clears;
      @(posedge clk) disable iff (!resetn)
      wr_ctrl && bus.wdata[`CRSA_BIT_UNAWARE]
         |=> !s_q.host_lo && !s_q.host_hi;
   endproperty
   a_unaware_clears: assert property (p_unaware_clears)
      else $error("host request survived host-unaware write");

   property p_ctl_lo_set;
      @(posedge clk) disable iff (!resetn)
      $rose(s_q.ctl_lo) |-> $past(!s_q.host_lo);
   endproperty
   a_ctl_lo_set: assert property (p_ctl_lo_set)
      else $error("controller low set while host low held");

   property p_ctl_hi_set;
      @(posedge clk) disable iff (!resetn)
      $rose(s_q.ctl_hi) |-> $past(!s_q.host_hi);
   endproperty
   a_ctl_hi_set: assert property (p_ctl_hi_set)
      else $error("controller high set while host high held");

   property p_host_lo_set;
      @(posedge clk) disable iff (!resetn)
      $rose(s_q.host_lo) |-> $past(!s_q.ctl_lo);
   endproperty
   a_host_lo_set: assert property (p_host_lo_set)
      else $error("host low set while controller low held");

   property p_host_hi_set;
      @(posedge clk) disable iff (!resetn)
      $rose(s_q.host_hi) |-> $past(!s_q.ctl_hi);
   endproperty
   a_host_hi_set: assert property (p_host_hi_set)
      else $error("host high set while controller high held");

   property p_never_both;
      @(posedge clk) disable iff (!resetn)
      !(s_q.ctl_lo && s_q.host_lo) && !(s_q.ctl_hi && s_q.host_hi);
   endproperty
   a_never_both: assert property (p_never_both)
      else $error("both request flags of one bank are set");

   property p_ctl_owner;
      @(posedge clk) disable iff (!resetn)
      !s_q.unaware && s_q.ctl_lo && !s_q.host_lo
         |-> s_q.grant.ctl_lo && !s_q.grant.host_lo;
   endproperty
   a_ctl_owner: assert property (p_ctl_owner)
      else $error("controller low owner not granted");

   property p_window_gate;
      @(posedge clk) disable iff (!resetn)
      bus.rd && bus.addr == `CRSA_OFS_WIN_LO && !s_q.grant.ctl_lo
         |=> s_q.rdata == 8'h00;
   endproperty
   a_window_gate: assert property (p_window_gate)
      else $error("low window read data without grant");

   property p_hi_window_gate;
      @(posedge clk) disable iff (!resetn)
      bus.rd && bus.addr == `CRSA_OFS_WIN_HI && !s_q.grant.ctl_hi
         |=> s_q.rdata == 8'h00;
   endproperty
   a_hi_window_gate: assert property (p_hi_window_gate)
      else $error("high window read data without grant");

   property p_force_open;
      @(posedge clk) disable iff (!resetn)
      force_open |=> s_q.grant.ctl_lo && s_q.grant.ctl_hi;
   endproperty
   a_force_open: assert property (p_force_open)
      else $error("controller shut out in reset or power-off");

   property p_ctl_hi_owner;
      @(posedge clk) disable iff (!resetn)
      !s_q.unaware && s_q.ctl_hi && !s_q.host_hi
         |-> s_q.grant.ctl_hi && !s_q.grant.host_hi;
   endproperty
   a_ctl_hi_owner: assert property (p_ctl_hi_owner)
      else $error("controller high owner not granted");

   property p_refused_lo;
      @(posedge clk) disable iff (!resetn)
      wr_ctrl && bus.wdata[`CRSA_BIT_CTL_LO] && s_q.host_lo
         |=> !s_q.ctl_lo;
   endproperty
   a_refused_lo: assert property (p_refused_lo)
      else $error("refused controller low request reads back set");

   property p_mirror_read;
      @(posedge clk) disable iff (!resetn)
      bus.rd && bus.addr == `CRSA_OFS_WIN_LO && s_q.grant.ctl_lo
         && s_q.idx_lo[6:0] == `CRSA_MIRROR_LOC
         |=> s_q.rdata == {$past(s_q.unaware), 3'h0, $past(s_q.ctl_hi),
                           $past(s_q.host_hi), $past(s_q.ctl_lo),
                           $past(s_q.host_lo)};
   endproperty
   a_mirror_read: assert property (p_mirror_read)
      else $error("mirror location does not show the control byte");

endmodule : crsa_arbiter

`default_nettype wire

// [testbench/crsa_host_model.sv]
`timescale 1ns/100ps
`default_nettype none

// Host side: a set line rises to ask for a bank, a clear line to let go
module crsa_host_model
   import crsa_pkg::*;
(
   // Clock
   input  wire logic          clk,
   // Bench commands
   input  wire logic          want_lo,
   input  wire logic          want_hi,
   // Host request lines
   output var  crsa_host_type host_req
);
   initial host_req = 4'h3;
   // Retries are made by dropping and raising the want level again
   always @(posedge clk) begin
      host_req <= {want_hi, want_lo, !want_hi, !want_lo};
   end
endmodule : crsa_host_model
`default_nettype wire

// [testbench/crsa_arbiter_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none

module crsa_arbiter_tb_top
   import crsa_pkg::*;
;
   logic           clk = 1'b0;
   logic           resetn = 1'b0;
   crsa_bus_type   bus;
   logic [7:0]     rdata;
   crsa_host_type  host_req;
   logic           sys_reset_active;
   logic           main_power_plane;
   crsa_grant_type grant;
   logic           want_lo;
   logic           want_hi;
   int             n_fail = 0;
   int             n_tests = 0;
   logic [31:0]    seed = 32'hff78;
   logic [7:0]     rd;
   logic [7:0]     ix;

   always #25 clk = ~clk;

   crsa_arbiter uut (.clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata),
      .host_req(host_req), .sys_reset_active(sys_reset_active),
      .main_power_plane(main_power_plane), .grant(grant));

   crsa_host_model host (.clk(clk), .want_lo(want_lo), .want_hi(want_hi),
      .host_req(host_req));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic logic [7:0] ctl(input int u, kh, hh, kl, hl);
      return {u[0], 3'h0, kh[0], hh[0], kl[0], hl[0]};
   endfunction : ctl

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic acc(input logic w, input logic [15:0] a,
                      input logic [7:0] d);
      @(negedge clk);
      bus = {w, !w, a, d};
      @(negedge clk);
      bus = '0;
      rd = rdata;
   endtask : acc

   task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      chk(rd, exp);
   endtask : rdc

   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask : wt

   task automatic end_of_test;
      $display("tests=%0d fails=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test

   initial begin
      #200000;
      n_fail++;
      end_of_test();
   end

   initial begin
      bus = '0;
      want_lo = 1'b0;
      want_hi = 1'b0;
      sys_reset_active = 1'b0;
      main_power_plane = 1'b1;
      wt(2);
      resetn = 1'b1;
      rdc(16'h7ff5, 8'h80);
      chk({4'h0, grant}, 8'h03);
      rdc(16'h7ff6, 8'h00);
      rdc(16'h7ff8, 8'h00);
      rdc(16'h7ffa, 8'h00);
      acc(1'b1, 16'h7ff5, ctl(0, 1, 0, 1, 0));
      rdc(16'h7ff5, 8'h0a);
      chk({4'h0, grant}, 8'h0c);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         ix = (seed[6:0] == 7'h7f) ? 8'h7e : seed[7:0];
         acc(1'b1, 16'h7ff6, ix);
         acc(1'b1, 16'h7ff7, seed[15:8]);
         acc(1'b1, 16'h7ff8, ix);
         acc(1'b1, 16'h7ff9, seed[23:16]);
         acc(1'b1, 16'h7ff6, ix ^ 8'h80);
         rdc(16'h7ff7, seed[15:8]);
         acc(1'b1, 16'h7ff8, ix ^ 8'h80);
         rdc(16'h7ff9, seed[23:16]);
      end
      acc(1'b1, 16'h7ff6, 8'hff);
      acc(1'b1, 16'h7ff7, 8'h55);
      rdc(16'h7ff7, 8'h0a);
      want_lo = 1'b1;
      wt(6);
      chk({4'h0, grant}, 8'h0c);
      acc(1'b1, 16'h7ff5, ctl(0, 1, 0, 0, 0));
      want_lo = 1'b0;
      wt(4);
      want_lo = 1'b1;
      wt(6);
      chk({4'h0, grant}, 8'h09);
      rdc(16'h7ff5, ctl(0, 1, 0, 0, 1));
      acc(1'b1, 16'h7ff6, ix);
      // Ungranted write must not land; read back once regained
      acc(1'b1, 16'h7ff7, ~seed[15:8]);
      rdc(16'h7ff7, 8'h00);
      acc(1'b1, 16'h7ff5, ctl(0, 1, 0, 1, 0));
      rdc(16'h7ff5, 8'h09);
      want_hi = 1'b1;
      wt(6);
      rdc(16'h7ff5, 8'h09);
      acc(1'b1, 16'h7ff5, 8'h00);
      rdc(16'h7ff9, 8'h00);
      want_hi = 1'b0;
      wt(4);
      want_hi = 1'b1;
      wt(6);
      rdc(16'h7ff5, ctl(0, 0, 1, 0, 1));
      acc(1'b1, 16'h7ff5, 8'h08);
      rdc(16'h7ff5, 8'h05);
      acc(1'b1, 16'h7ff5, 8'h80);
      rdc(16'h7ff5, 8'h80);
      chk({4'h0, grant}, 8'h03);
      main_power_plane = 1'b0;
      wt(6);
      chk({4'h0, grant}, 8'h0f);
      main_power_plane = 1'b1;
      sys_reset_active = 1'b1;
      wt(6);
      chk({4'h0, grant}, 8'h0f);
      sys_reset_active = 1'b0;
      wt(6);
      acc(1'b1, 16'h7ff5, 8'h08);
      chk({4'h0, grant}, 8'h08);
      // Index is rewritten after regaining the bank
      acc(1'b1, 16'h7ff8, ix);
      rdc(16'h7ff9, seed[23:16]);
      acc(1'b1, 16'h7ff5, 8'h0a);
      chk({4'h0, grant}, 8'h0c);
      acc(1'b1, 16'h7ff6, ix);
      rdc(16'h7ff7, seed[15:8]);
      end_of_test();
   end
endmodule : crsa_arbiter_tb_top
`default_nettype wire
